// ### dpgc_pkg.sv
package dpgc_pkg;
  // configuration register offsets (byte addresses)
  localparam logic [11:0] DPGC_OFS_TUNING = 12'h0d0;
  localparam logic [11:0] DPGC_OFS_GENCTL = 12'h0d4;
  // reset values
  localparam logic [31:0] DPGC_TUNING_RST = 32'h32140000;
  localparam logic DPGC_VENDOR_BIT_RST = 1'h0;
  localparam logic DPGC_CLK_GATE_RST = 1'h0;
  localparam logic DPGC_PFIP_RST = 1'h0;
  // field positions of the general control register
  localparam int DPGC_BIT_VENDOR = 16;
  localparam int DPGC_BIT_CLK_GATE = 15;
  localparam int DPGC_BIT_HPC = 14;
  localparam int DPGC_BIT_HPS = 13;
  localparam int DPGC_BIT_PFIP = 6;

  // configuration access request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } dpgc_cfg_req_s;

  // preload word from the serial eeprom loader
  typedef struct packed {
    logic valid;
    logic [11:0] addr;
    logic [31:0] data;
  } dpgc_preload_s;
endpackage

// ### dpgc_port_ctrl.sv
`timescale 1ns/1ps
module dpgc_port_ctrl
  import dpgc_pkg::*;
(
  // clock and fundamental reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // configuration access
  input wire dpgc_cfg_req_s cfg_req_i,
  output logic [31:0] cfg_rdata_o,
  output logic cfg_ack_o,
  // eeprom preload
  input wire dpgc_preload_s preload_i,
  // pins
  input wire logic downstream_port_strap_pin_i,
  input wire logic slot_power_fault_in_i,
  // outputs
  output logic port_reference_clock_out_en_o,
  output logic slotcap_hot_plug_capable_o,
  output logic slotcap_hot_plug_surprise_o
);

  logic strap_s1, strap_s2, fault_s1, fault_s2;
  logic strap_pend;
  logic [31:0] tuning, next_tuning;
  logic vendor_reserved_bit, next_vendor_reserved_bit;
  logic clk_gate_on_fault_en, next_clk_gate_on_fault_en;
  logic hot_plug_capable_cfg, next_hot_plug_capable_cfg;
  logic hot_plug_surprise_cfg, next_hot_plug_surprise_cfg;
  logic power_fault_input_present, next_power_fault_input_present;
  logic [31:0] next_rdata;
  logic next_refclk_en;
  logic [31:0] genctl_view;
  logic [31:0] wmask;

  // pin synchronisers; second stage only is read
  always_ff @(posedge core_clk_i) begin
    strap_s1 <= downstream_port_strap_pin_i;
    strap_s2 <= strap_s1;
    fault_s1 <= slot_power_fault_in_i;
    fault_s2 <= fault_s1;
  end

  // strap is caught once after reset release, when synchronised value has settled
  logic [1:0] strap_wait, next_strap_wait;
  // counter parks at 3 so a strap that moves later never overwrites software's choice
  always_comb begin
    next_strap_wait = strap_wait;
    if (strap_wait != 2'h3) begin
      next_strap_wait = strap_wait + 2'h1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      strap_wait <= 2'h0;
    end else begin
      strap_wait <= next_strap_wait;
    end
  end
  assign strap_pend = (strap_wait == 2'h2);

  always_comb begin
    wmask = {{8{cfg_req_i.be[3]}}, {8{cfg_req_i.be[2]}}, {8{cfg_req_i.be[1]}}, {8{cfg_req_i.be[0]}}};
    next_tuning = tuning;
    next_vendor_reserved_bit = vendor_reserved_bit;
    next_clk_gate_on_fault_en = clk_gate_on_fault_en;
    next_hot_plug_capable_cfg = hot_plug_capable_cfg;
    next_hot_plug_surprise_cfg = hot_plug_surprise_cfg;
    next_power_fault_input_present = power_fault_input_present;
    if (strap_pend) begin
      next_hot_plug_capable_cfg = strap_s2;
      next_hot_plug_surprise_cfg = strap_s2;
    end
    if (preload_i.valid && preload_i.addr == DPGC_OFS_TUNING) begin
      next_tuning = preload_i.data;
    end
    if (preload_i.valid && preload_i.addr == DPGC_OFS_GENCTL) begin
      next_vendor_reserved_bit = preload_i.data[DPGC_BIT_VENDOR];
      next_clk_gate_on_fault_en = preload_i.data[DPGC_BIT_CLK_GATE];
      next_hot_plug_capable_cfg = preload_i.data[DPGC_BIT_HPC];
      next_hot_plug_surprise_cfg = preload_i.data[DPGC_BIT_HPS];
      next_power_fault_input_present = preload_i.data[DPGC_BIT_PFIP];
    end
    // software may write the tuning word freely
    if (cfg_req_i.wr && cfg_req_i.addr == DPGC_OFS_TUNING) begin
      next_tuning = (tuning & ~wmask) | (cfg_req_i.wdata & wmask);
    end
    // only read/write fields take write data
    if (cfg_req_i.wr && cfg_req_i.addr == DPGC_OFS_GENCTL) begin
      if (cfg_req_i.be[2]) begin
        next_vendor_reserved_bit = cfg_req_i.wdata[DPGC_BIT_VENDOR];
      end
      if (cfg_req_i.be[1]) begin
        next_clk_gate_on_fault_en = cfg_req_i.wdata[DPGC_BIT_CLK_GATE];
        next_hot_plug_capable_cfg = cfg_req_i.wdata[DPGC_BIT_HPC];
        next_hot_plug_surprise_cfg = cfg_req_i.wdata[DPGC_BIT_HPS];
      end
      if (cfg_req_i.be[0]) begin
        next_power_fault_input_present = cfg_req_i.wdata[DPGC_BIT_PFIP];
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      tuning <= DPGC_TUNING_RST;
      vendor_reserved_bit <= DPGC_VENDOR_BIT_RST;
      clk_gate_on_fault_en <= DPGC_CLK_GATE_RST;
      hot_plug_capable_cfg <= 1'h0;
      hot_plug_surprise_cfg <= 1'h0;
      power_fault_input_present <= DPGC_PFIP_RST;
    end else begin
      tuning <= next_tuning;
      vendor_reserved_bit <= next_vendor_reserved_bit;
      clk_gate_on_fault_en <= next_clk_gate_on_fault_en;
      hot_plug_capable_cfg <= next_hot_plug_capable_cfg;
      hot_plug_surprise_cfg <= next_hot_plug_surprise_cfg;
      power_fault_input_present <= next_power_fault_input_present;
    end
  end

  always_comb begin
    genctl_view = 32'h00000000;
    genctl_view[DPGC_BIT_VENDOR] = vendor_reserved_bit;
    genctl_view[DPGC_BIT_CLK_GATE] = clk_gate_on_fault_en;
    genctl_view[DPGC_BIT_HPC] = hot_plug_capable_cfg;
    genctl_view[DPGC_BIT_HPS] = hot_plug_surprise_cfg;
    genctl_view[DPGC_BIT_PFIP] = power_fault_input_present;
  end

  always_comb begin
    next_rdata = 32'h00000000;
    if (cfg_req_i.rd && cfg_req_i.addr == DPGC_OFS_TUNING) begin
      next_rdata = tuning;
    end else if (cfg_req_i.rd && cfg_req_i.addr == DPGC_OFS_GENCTL) begin
      next_rdata = genctl_view;
    end
  end

  always_comb begin
    next_refclk_en = !(clk_gate_on_fault_en && power_fault_input_present && fault_s2);
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      cfg_rdata_o <= 32'h00000000;
      cfg_ack_o <= 1'h0;
      port_reference_clock_out_en_o <= 1'h0;
      slotcap_hot_plug_capable_o <= 1'h0;
      slotcap_hot_plug_surprise_o <= 1'h0;
    end else begin
      cfg_rdata_o <= next_rdata;
      cfg_ack_o <= cfg_req_i.rd | cfg_req_i.wr;
      port_reference_clock_out_en_o <= next_refclk_en;
      slotcap_hot_plug_capable_o <= hot_plug_capable_cfg;
      slotcap_hot_plug_surprise_o <= hot_plug_surprise_cfg;
    end
  end

  AST_TUNING_RST: assert property (@(posedge core_clk_i) $rose(nrst_i) |-> tuning == 32'h32140000)
    else $error("tuning word not at default after reset");

  AST_RSVD_ZERO: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    $past(cfg_req_i.rd) && $past(cfg_req_i.addr) == DPGC_OFS_GENCTL |-> cfg_rdata_o[31:17] == 15'h0000)
    else $error("reserved general control bits not zero");

  AST_CLK_GATED: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    clk_gate_on_fault_en && power_fault_input_present && fault_s2 ##1 nrst_i |-> !port_reference_clock_out_en_o)
    else $error("reference clock not gated on fault");

  AST_CLK_UNGATED: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    !clk_gate_on_fault_en ##1 nrst_i |-> port_reference_clock_out_en_o)
    else $error("reference clock gated while gating off");

  AST_PFIP_OFF: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    !power_fault_input_present ##1 nrst_i |-> port_reference_clock_out_en_o)
    else $error("fault pin used while not present");

  AST_HPC_OUT: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    ##1 nrst_i |-> slotcap_hot_plug_capable_o == $past(hot_plug_capable_cfg))
    else $error("hot plug capable output mismatch");

  AST_HPS_OUT: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    ##1 nrst_i |-> slotcap_hot_plug_surprise_o == $past(hot_plug_surprise_cfg))
    else $error("hot plug surprise output mismatch");

  AST_STRAP: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    strap_pend && !preload_i.valid && !cfg_req_i.wr |=> hot_plug_capable_cfg == $past(strap_s2)
      && hot_plug_surprise_cfg == $past(strap_s2))
    else $error("strap default not taken");

  AST_PRELOAD: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    preload_i.valid && preload_i.addr == DPGC_OFS_GENCTL && !cfg_req_i.wr
      |=> clk_gate_on_fault_en == $past(preload_i.data[15]))
    else $error("eeprom preload not applied");

  AST_WR_FIELD: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    cfg_req_i.wr && cfg_req_i.addr == DPGC_OFS_GENCTL && cfg_req_i.be[1]
      |=> clk_gate_on_fault_en == $past(cfg_req_i.wdata[15]))
    else $error("general control write lost");

  // request, write and fault-clear steps shared by the checks below
  sequence seq_any_req;
    cfg_req_i.rd || cfg_req_i.wr;
  endsequence

  sequence seq_genctl_wr;
    cfg_req_i.wr && cfg_req_i.addr == DPGC_OFS_GENCTL;
  endsequence

  sequence seq_tuning_wr;
    cfg_req_i.wr && cfg_req_i.addr == DPGC_OFS_TUNING && !preload_i.valid;
  endsequence

  sequence seq_fault_clear;
    !fault_s2;
  endsequence

  AST_ACK_PULSE: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    seq_any_req |=> cfg_ack_o)
    else $error("request not acknowledged");

  AST_ACK_IDLE: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    !cfg_req_i.rd && !cfg_req_i.wr |=> !cfg_ack_o)
    else $error("acknowledge without request");

  AST_RD_GENCTL: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    cfg_req_i.rd && cfg_req_i.addr == DPGC_OFS_GENCTL |=> cfg_rdata_o[15] == $past(clk_gate_on_fault_en)
      && cfg_rdata_o[6] == $past(power_fault_input_present))
    else $error("general control read data wrong");

  AST_RD_UNMAPPED: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    cfg_req_i.rd && cfg_req_i.addr != DPGC_OFS_TUNING && cfg_req_i.addr != DPGC_OFS_GENCTL |=> cfg_rdata_o == 32'h00000000)
    else $error("unmapped read not zero");

  AST_RD_TUNING: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    cfg_req_i.rd && cfg_req_i.addr == DPGC_OFS_TUNING |=> cfg_rdata_o == $past(tuning))
    else $error("tuning read data wrong");

  AST_TUNING_WR: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    seq_tuning_wr ##0 cfg_req_i.be == 4'hf |=> tuning == $past(cfg_req_i.wdata))
    else $error("tuning write lost");

  AST_TUNING_HOLD: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    !(cfg_req_i.wr && cfg_req_i.addr == DPGC_OFS_TUNING) && !(preload_i.valid && preload_i.addr == DPGC_OFS_TUNING)
      |=> $stable(tuning))
    else $error("tuning word moved without access");

  AST_TUNING_PRELOAD: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    preload_i.valid && preload_i.addr == DPGC_OFS_TUNING && !(cfg_req_i.wr && cfg_req_i.addr == DPGC_OFS_TUNING)
      |=> tuning == $past(preload_i.data))
    else $error("tuning preload not applied");

  AST_WR_VENDOR: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    seq_genctl_wr ##0 cfg_req_i.be[2] |=> vendor_reserved_bit == $past(cfg_req_i.wdata[DPGC_BIT_VENDOR]))
    else $error("vendor bit write lost");

  AST_PFIP_WR: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    seq_genctl_wr ##0 cfg_req_i.be[0] |=> power_fault_input_present == $past(cfg_req_i.wdata[DPGC_BIT_PFIP]))
    else $error("fault input present write lost");

  AST_WR_MASKED: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    seq_genctl_wr ##0 !cfg_req_i.be[1] && !preload_i.valid && !strap_pend
      |=> $stable(clk_gate_on_fault_en) && $stable(hot_plug_capable_cfg) && $stable(hot_plug_surprise_cfg))
    else $error("masked byte changed fields");

  AST_FAULT_CLEAR: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    seq_fault_clear ##1 nrst_i |-> port_reference_clock_out_en_o)
    else $error("reference clock off without fault");
endmodule

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
  import dpgc_pkg::*;
  logic core_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  dpgc_cfg_req_s cfg_req_i = '0;
  dpgc_preload_s preload_i = '0;
  logic strap_pin = 1'b1;
  logic fault_in = 1'b0;
  logic [31:0] cfg_rdata_o;
  logic cfg_ack_o, refclk_en, slotcap_hot_plug_capable, slotcap_hot_plug_surprise;
  logic [31:0] exp_q[$];
  logic [31:0] rval;
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;

  always #12.5 core_clk_i = ~core_clk_i;

  dpgc_port_ctrl u_dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .cfg_req_i(cfg_req_i),
    .cfg_rdata_o(cfg_rdata_o), .cfg_ack_o(cfg_ack_o), .preload_i(preload_i),
    .downstream_port_strap_pin_i(strap_pin), .slot_power_fault_in_i(fault_in),
    .port_reference_clock_out_en_o(refclk_en), .slotcap_hot_plug_capable_o(slotcap_hot_plug_capable),
    .slotcap_hot_plug_surprise_o(slotcap_hot_plug_surprise));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // every request leaves one note; writes answer with zero data
  task automatic req(input logic r, input logic [11:0] a, input logic [3:0] be, input logic [31:0] d,
                     input logic [31:0] e);
    @(posedge core_clk_i);
    cfg_req_i <= '{rd: r, wr: ~r, addr: a, be: be, wdata: d};
    exp_q.push_back(e);
    @(posedge core_clk_i);
    cfg_req_i <= '0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
    req(1'b0, a, be, d, 32'h0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    req(1'b1, a, 4'hf, 32'h0, e);
  endtask

  task automatic pl(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    preload_i <= '{valid: 1'b1, addr: a, data: d};
    @(posedge core_clk_i);
    preload_i <= '0;
  endtask

  // two strap/fault synchroniser edges plus the output flop need three edges
  task automatic lvl(input int n, input logic [2:0] e);
    repeat (n) @(posedge core_clk_i);
    #1;
    chk({29'h0, refclk_en, slotcap_hot_plug_capable, slotcap_hot_plug_surprise}, {29'h0, e});
  endtask

  task automatic rst(input logic s);
    @(posedge core_clk_i);
    nrst_i <= 1'b0;
    strap_pin <= s;
    repeat (6) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    repeat (5) @(posedge core_clk_i);
  endtask

  // the watcher pops one note per acknowledge
  always @(negedge core_clk_i) begin
    cycles++;
    if (cfg_ack_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(cfg_rdata_o, 32'hxxxx_xxxx);
      end else begin
        chk(cfg_rdata_o, exp_q.pop_front());
      end
    end
    if (cycles > 3000) begin
      fail_count++;
      final_report();
    end
  end

  initial begin
    void'($urandom(1));
    rst(1'b1);
    lvl(0, 3'b111);
    rd(DPGC_OFS_TUNING, DPGC_TUNING_RST);
    rd(DPGC_OFS_GENCTL, 32'h0000_6000);
    wr(DPGC_OFS_GENCTL, 4'hf, 32'hfffe_ffff);
    rd(DPGC_OFS_GENCTL, 32'h0000_e040);
    @(posedge core_clk_i) fault_in <= 1'b1;
    lvl(4, 3'b011);
    @(posedge core_clk_i) fault_in <= 1'b0;
    lvl(4, 3'b111);
    wr(DPGC_OFS_GENCTL, 4'hf, 32'h0000_0040);
    @(posedge core_clk_i) fault_in <= 1'b1;
    lvl(4, 3'b100);
    wr(DPGC_OFS_GENCTL, 4'hf, 32'h0000_8000);
    lvl(4, 3'b100);
    @(posedge core_clk_i) fault_in <= 1'b0;
    // byte 1 masked off keeps bits 15..13 as they were
    wr(DPGC_OFS_GENCTL, 4'b1101, 32'hfffe_ffff);
    rd(DPGC_OFS_GENCTL, 32'h0000_8040);
    rval = $urandom;
    wr(DPGC_OFS_TUNING, 4'hf, rval);
    rd(DPGC_OFS_TUNING, rval);
    wr(12'h0d8, 4'hf, $urandom);
    rd(12'h0d8, 32'h0);
    rst(1'b0);
    rd(DPGC_OFS_TUNING, DPGC_TUNING_RST);
    rd(DPGC_OFS_GENCTL, 32'h0);
    lvl(0, 3'b100);
    pl(DPGC_OFS_GENCTL, 32'h0000_e040);
    lvl(2, 3'b111);
    rd(DPGC_OFS_GENCTL, 32'h0000_e040);
    @(posedge core_clk_i) fault_in <= 1'b1;
    lvl(4, 3'b011);
    wr(DPGC_OFS_TUNING, 4'hf, $urandom);
    pl(DPGC_OFS_TUNING, DPGC_TUNING_RST);
    rd(DPGC_OFS_TUNING, DPGC_TUNING_RST);
    repeat (3) @(posedge core_clk_i);
    final_report();
  end
endmodule
